// [src/nv_pkg.sv]
// Shared constants for the byte-wide nonvolatile store controller.
// Assumes a single 20 MHz system clock and an AXI4-Lite register port.
package nv_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned WRITE_TIME_NS = 2000;   // Plain default, no figure given
  localparam int unsigned WRITE_CYCLES  = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TMR_W         = 16;
  localparam int unsigned JITTER_W      = 4;

  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int unsigned NV_AW = 8;
  localparam int unsigned NV_DW = 8;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_ADDR   = 8'h00;
  localparam logic [7:0] OFF_DATA   = 8'h04;
  localparam logic [7:0] OFF_PLOW   = 8'h08;
  localparam logic [7:0] OFF_PHIGH  = 8'h0c;
  localparam logic [7:0] OFF_IND    = 8'h10;
  localparam logic [7:0] OFF_IRQ    = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;

  // Pointer value that reaches the control register in sector 1
  localparam logic [7:0] PTR_CTRL_LOW  = 8'h40;
  localparam logic [7:0] PTR_CTRL_HIGH = 8'h01;
  localparam logic [7:0] PTR_RESET     = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_RD_STROBE = 0;
  localparam int unsigned CTRL_RD_ARM    = 1;
  localparam int unsigned CTRL_WR_STROBE = 2;
  localparam int unsigned CTRL_WR_ARM    = 3;
  localparam int unsigned IRQ_GIE        = 0;
  localparam int unsigned IRQ_IE         = 1;
  localparam int unsigned IRQ_FLAG       = 2;
  localparam int unsigned STAT_BUSY      = 0;
  localparam int unsigned STAT_RD        = 1;
  localparam int unsigned STAT_WR        = 2;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [7:0] BYTE_ZERO   = 8'h00;

  typedef enum logic [1:0] {
    ST_IDLE     = 2'b00,
    ST_RD_ISSUE = 2'b01,
    ST_RD_TAKE  = 2'b11,
    ST_WR_BUSY  = 2'b10
  } nv_state_t;

  typedef enum logic [2:0] {
    SEL_ADDR   = 3'h0,
    SEL_DATA   = 3'h1,
    SEL_PLOW   = 3'h2,
    SEL_PHIGH  = 3'h3,
    SEL_IND    = 3'h4,
    SEL_IRQ    = 3'h5,
    SEL_STATUS = 3'h6,
    SEL_NONE   = 3'h7
  } reg_sel_t;

endpackage

// [src/nv_array.sv]
// Byte-wide storage array with one write port and a registered read port.
// Assumes the controller never reads and writes the same cycle.
`timescale 1ns/10ps
`default_nettype none

module nv_array #(
  parameter int unsigned AW = nv_pkg::NV_AW,
  parameter int unsigned DW = nv_pkg::NV_DW
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic          re,
  input  wire logic [AW-1:0] raddr,
  output logic      [DW-1:0] rdata_q
);

  logic [DW-1:0] mem [2**AW];
  logic [DW-1:0] rdata_d;

  // Read data only move on a read, so the output holds between reads
  always_comb begin
    rdata_d = rdata_q;
    if (re) begin
      rdata_d = mem[raddr];
    end
  end

  // Contents are not reset: the array keeps its data across resets
  always_ff @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    if (!aresetn) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= rdata_d;
    end
  end

endmodule

`default_nettype wire

// [src/nv_write_timer.sv]
// Programming timer for one write cycle.
// Stands in for a free-running oscillator that is not locked to aclk: the
// length varies by a pseudo-random jitter so software cannot count cycles.
`timescale 1ns/10ps
`default_nettype none

module nv_write_timer #(
  parameter int unsigned CYCLES = nv_pkg::WRITE_CYCLES
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic start,
  output logic      done_q
);

  localparam int unsigned W = nv_pkg::TMR_W;
  localparam int unsigned J = nv_pkg::JITTER_W;
  localparam logic [W-1:0] BASE = W'(CYCLES);

  logic [W-1:0] cnt_q, cnt_d;
  logic [7:0]   lfsr_q, lfsr_d;
  logic         run_q, run_d;
  logic         done_d;

  // Free-running shift register gives the phase offset of each cycle
  always_comb begin
    lfsr_d = {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
    cnt_d  = cnt_q;
    run_d  = run_q;
    done_d = 1'b0;
    if (start) begin
      cnt_d = BASE + {{(W-J){1'b0}}, lfsr_q[J-1:0]};
      run_d = 1'b1;
    end else if (run_q) begin
      if (cnt_q <= {{(W-1){1'b0}}, 1'b1}) begin
        run_d  = 1'b0;
        done_d = 1'b1;
      end else begin
        cnt_d = cnt_q - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  // Seed is any non-zero constant
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lfsr_q <= 8'h5a;
      cnt_q  <= '0;
      run_q  <= 1'b0;
      done_q <= 1'b0;
    end else begin
      lfsr_q <= lfsr_d;
      cnt_q  <= cnt_d;
      run_q  <= run_d;
      done_q <= done_d;
    end
  end

endmodule

`default_nettype wire

// [src/nv_byte_ctrl.sv]
// Byte read/write controller for a 256-byte nonvolatile store, with an
// AXI4-Lite register port, indirect control access and a write-done interrupt.
// Assumes the interrupt controller sits on aclk and pulses irq_serviced.
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// R01 - Software loads address before a read
// R02 - Read strobe with read arm starts read
// R03 - Read strobe without read arm is ignored
// R04 - Hardware clears read strobe, data then valid
// R05 - Data register holds until next operation
// R06 - Software loads address and data before write
// R07 - Write strobe follows write arm immediately
// R08 - Software masks global interrupts around start
// R09 - Write strobe without write arm is ignored
// R10 - Write length comes from an unlocked timer
// R11 - Hardware clears write strobe at completion
// R12 - Write arm is clear after reset
// R13 - Pointer high byte resets to sector zero
// R14 - Write end sets flag, enable gates it
// R15 - Request needs both enables, stack not full
// R16 - Servicing the interrupt clears the flag
// R17 - No sleep until the cycle has finished
// R18 - Rewrite address before every read
// R19 - Control reached through pointer 01H:40H
// R20 - Keep write arm clear when idle
// R21 - Array is 256 bytes, 8-bit address
// R22 - Never set all four control bits together
// R23 - Address and data latched at cycle start
module nv_byte_ctrl #(
  parameter int unsigned ADDR_W       = 8,
  parameter int unsigned WRITE_CYCLES = nv_pkg::WRITE_CYCLES
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              stack_full,
  input  wire logic              irq_serviced,
  output logic                   irq_request,
  output logic                   nv_busy
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------

  // Maps a bus address to a register; misaligned words are unmapped
  function automatic nv_pkg::reg_sel_t reg_sel(input logic [ADDR_W-1:0] a);
    logic [7:0] off;
    off = a[7:0];
    if (off[1:0] != 2'b00) begin
      return nv_pkg::SEL_NONE;
    end
    unique case (off)
      nv_pkg::OFF_ADDR:   return nv_pkg::SEL_ADDR;
      nv_pkg::OFF_DATA:   return nv_pkg::SEL_DATA;
      nv_pkg::OFF_PLOW:   return nv_pkg::SEL_PLOW;
      nv_pkg::OFF_PHIGH:  return nv_pkg::SEL_PHIGH;
      nv_pkg::OFF_IND:    return nv_pkg::SEL_IND;
      nv_pkg::OFF_IRQ:    return nv_pkg::SEL_IRQ;
      nv_pkg::OFF_STATUS: return nv_pkg::SEL_STATUS;
      default:            return nv_pkg::SEL_NONE;
    endcase
  endfunction

  // The control register answers only when the pointer selects it
  function automatic logic ctrl_reached(input logic [7:0] hi, input logic [7:0] lo);
    return (hi == nv_pkg::PTR_CTRL_HIGH) && (lo == nv_pkg::PTR_CTRL_LOW);  // [R19] [R13]
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0]       awaddr_q, awaddr_d;
  logic [7:0]              wbyte_q, wbyte_d;
  logic                    wlane_q, wlane_d;
  logic                    aw_full_q, aw_full_d, w_full_q, w_full_d;
  logic                    awready_q, awready_d, wready_q, wready_d;
  logic                    bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
  logic [1:0]              bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0]             rdata_q, rdata_d;
  logic                    wr_fire;
  nv_pkg::reg_sel_t        wr_sel;

  nv_pkg::nv_state_t       state_q, state_d;
  logic [nv_pkg::NV_AW-1:0] nv_addr_reg_q, nv_addr_reg_d, op_addr_q, op_addr_d;
  logic [nv_pkg::NV_DW-1:0] nv_data_reg_q, nv_data_reg_d, op_data_q, op_data_d;
  logic [7:0]              pointer1_low_q, pointer1_low_d, pointer1_high_q, pointer1_high_d;
  logic                    read_arm_q, read_arm_d, write_arm_q, write_arm_d;
  logic                    rd_strobe_q, rd_strobe_d, wr_strobe_q, wr_strobe_d;
  logic                    global_irq_enable_q, global_irq_enable_d;
  logic                    nv_write_irq_enable_q, nv_write_irq_enable_d;
  logic                    nv_write_irq_flag_q, nv_write_irq_flag_d;
  logic                    mem_we_q, mem_we_d, mem_re_q, mem_re_d, tmr_start_q, tmr_start_d;
  logic                    irq_q, irq_d, busy_q, busy_d;
  logic [nv_pkg::NV_DW-1:0] mem_rdata;
  logic                    tmr_done;

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------

  // Address and data are taken in either order; the write acts once
  // both are held and no response is still waiting.
  always_comb begin
    awaddr_d  = awaddr_q;
    wbyte_d   = wbyte_q;
    wlane_d   = wlane_q;
    aw_full_d = aw_full_q;
    w_full_d  = w_full_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    arready_d = arready_q;
    rvalid_d  = rvalid_q;
    rresp_d   = rresp_q;
    rdata_d   = rdata_q;
    wr_fire   = 1'b0;
    wr_sel    = reg_sel(awaddr_q);
    if (s_axi_awvalid && awready_q) begin
      awaddr_d  = s_axi_awaddr;
      aw_full_d = 1'b1;
    end
    if (s_axi_wvalid && wready_q) begin
      wbyte_d  = s_axi_wdata[7:0];
      wlane_d  = s_axi_wstrb[0];
      w_full_d = 1'b1;
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (aw_full_q && w_full_q && !bvalid_q) begin
      wr_fire   = wlane_q && (wr_sel != nv_pkg::SEL_NONE) && (wr_sel != nv_pkg::SEL_STATUS);
      aw_full_d = 1'b0;
      w_full_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = (wr_sel == nv_pkg::SEL_NONE) ? nv_pkg::RESP_SLVERR : nv_pkg::RESP_OKAY;
    end
    awready_d = !aw_full_d && !bvalid_d;
    wready_d  = !w_full_d && !bvalid_d;
    // Read side: one outstanding read, answered the cycle after it is taken
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d  = nv_pkg::RESP_OKAY;
      rdata_d  = '0;
      unique case (reg_sel(s_axi_araddr))
        nv_pkg::SEL_ADDR:  rdata_d[7:0] = nv_addr_reg_q;
        nv_pkg::SEL_DATA:  rdata_d[7:0] = nv_data_reg_q;
        nv_pkg::SEL_PLOW:  rdata_d[7:0] = pointer1_low_q;
        nv_pkg::SEL_PHIGH: rdata_d[7:0] = pointer1_high_q;
        nv_pkg::SEL_IND: begin
          if (ctrl_reached(pointer1_high_q, pointer1_low_q)) begin
            rdata_d[nv_pkg::CTRL_RD_STROBE] = rd_strobe_q;
            rdata_d[nv_pkg::CTRL_RD_ARM]    = read_arm_q;
            rdata_d[nv_pkg::CTRL_WR_STROBE] = wr_strobe_q;
            rdata_d[nv_pkg::CTRL_WR_ARM]    = write_arm_q;
          end
        end
        nv_pkg::SEL_IRQ: begin
          rdata_d[nv_pkg::IRQ_GIE]  = global_irq_enable_q;
          rdata_d[nv_pkg::IRQ_IE]   = nv_write_irq_enable_q;
          rdata_d[nv_pkg::IRQ_FLAG] = nv_write_irq_flag_q;
        end
        nv_pkg::SEL_STATUS: begin
          rdata_d[nv_pkg::STAT_BUSY] = busy_q;
          rdata_d[nv_pkg::STAT_RD]   = rd_strobe_q;
          rdata_d[nv_pkg::STAT_WR]   = wr_strobe_q;
        end
        nv_pkg::SEL_NONE:  rresp_d = nv_pkg::RESP_SLVERR;
      endcase
    end
    arready_d = !rvalid_d;
  end

  // Bus handshake registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awaddr_q  <= '0;
      wbyte_q   <= nv_pkg::BYTE_ZERO;
      wlane_q   <= 1'b0;
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= nv_pkg::RESP_OKAY;
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rresp_q   <= nv_pkg::RESP_OKAY;
      rdata_q   <= '0;
    end else begin
      awaddr_q  <= awaddr_d;
      wbyte_q   <= wbyte_d;
      wlane_q   <= wlane_d;
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      arready_q <= arready_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
    end
  end

  // ----------------------------------------------------------------
  // Register file, cycle sequencer and interrupt request
  // ----------------------------------------------------------------

  // Software writes first, hardware events after, so a completing cycle
  // wins over a software write in the same clock.
  always_comb begin
    state_d               = state_q;
    nv_addr_reg_d         = nv_addr_reg_q;
    nv_data_reg_d         = nv_data_reg_q;
    op_addr_d             = op_addr_q;
    op_data_d             = op_data_q;
    pointer1_low_d        = pointer1_low_q;
    pointer1_high_d       = pointer1_high_q;
    read_arm_d            = read_arm_q;
    write_arm_d           = write_arm_q;
    rd_strobe_d           = rd_strobe_q;
    wr_strobe_d           = wr_strobe_q;
    global_irq_enable_d   = global_irq_enable_q;
    nv_write_irq_enable_d = nv_write_irq_enable_q;
    nv_write_irq_flag_d   = nv_write_irq_flag_q;
    mem_we_d              = 1'b0;
    mem_re_d              = 1'b0;
    tmr_start_d           = 1'b0;
    if (wr_fire) begin
      unique case (wr_sel)
        nv_pkg::SEL_ADDR:  nv_addr_reg_d   = wbyte_q;
        nv_pkg::SEL_DATA:  nv_data_reg_d   = wbyte_q;
        nv_pkg::SEL_PLOW:  pointer1_low_d  = wbyte_q;
        nv_pkg::SEL_PHIGH: pointer1_high_d = wbyte_q;
        nv_pkg::SEL_IND: begin
          if (ctrl_reached(pointer1_high_q, pointer1_low_q)) begin  // [R19]
            read_arm_d  = wbyte_q[nv_pkg::CTRL_RD_ARM];
            write_arm_d = wbyte_q[nv_pkg::CTRL_WR_ARM];
            // Strobes act only against an arm already set; a zero is ignored
            if (state_q == nv_pkg::ST_IDLE) begin
              if (wbyte_q[nv_pkg::CTRL_WR_STROBE] && write_arm_q) begin  // [R09]
                wr_strobe_d = 1'b1;
                tmr_start_d = 1'b1;                                      // [R10]
                op_addr_d   = nv_addr_reg_q;                             // [R23]
                op_data_d   = nv_data_reg_q;                             // [R23]
                state_d     = nv_pkg::ST_WR_BUSY;
              end else if (wbyte_q[nv_pkg::CTRL_RD_STROBE] && read_arm_q) begin  // [R02] [R03]
                rd_strobe_d = 1'b1;
                mem_re_d    = 1'b1;
                op_addr_d   = nv_addr_reg_q;                             // [R23]
                state_d     = nv_pkg::ST_RD_ISSUE;
              end
            end
          end
        end
        nv_pkg::SEL_IRQ: begin
          global_irq_enable_d   = wbyte_q[nv_pkg::IRQ_GIE];
          nv_write_irq_enable_d = wbyte_q[nv_pkg::IRQ_IE];
          if (!wbyte_q[nv_pkg::IRQ_FLAG]) begin
            nv_write_irq_flag_d = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    if (irq_serviced) begin
      nv_write_irq_flag_d = 1'b0;                                        // [R16]
    end
    unique case (state_q)
      nv_pkg::ST_IDLE: begin
      end
      nv_pkg::ST_RD_ISSUE: begin
        state_d = nv_pkg::ST_RD_TAKE;
      end
      nv_pkg::ST_RD_TAKE: begin
        nv_data_reg_d = mem_rdata;                                       // [R04] [R05]
        rd_strobe_d   = 1'b0;                                            // [R04]
        state_d       = nv_pkg::ST_IDLE;
      end
      nv_pkg::ST_WR_BUSY: begin
        if (tmr_done) begin                                              // [R10]
          mem_we_d            = 1'b1;
          wr_strobe_d         = 1'b0;                                    // [R11]
          nv_write_irq_flag_d = 1'b1;                                    // [R14]
          state_d             = nv_pkg::ST_IDLE;
        end
      end
    endcase
    irq_d  = global_irq_enable_q && nv_write_irq_enable_q
             && nv_write_irq_flag_q && !stack_full;                      // [R14] [R15]
    busy_d = (state_d != nv_pkg::ST_IDLE);
  end

  // Arm bits and pointer high byte clear on reset to block stray writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q               <= nv_pkg::ST_IDLE;
      nv_addr_reg_q         <= '0;
      nv_data_reg_q         <= '0;
      op_addr_q             <= '0;
      op_data_q             <= '0;
      pointer1_low_q        <= nv_pkg::PTR_RESET;
      pointer1_high_q       <= nv_pkg::PTR_RESET;                        // [R13]
      read_arm_q            <= 1'b0;
      write_arm_q           <= 1'b0;                                     // [R12]
      rd_strobe_q           <= 1'b0;
      wr_strobe_q           <= 1'b0;
      global_irq_enable_q   <= 1'b0;
      nv_write_irq_enable_q <= 1'b0;
      nv_write_irq_flag_q   <= 1'b0;
      mem_we_q              <= 1'b0;
      mem_re_q              <= 1'b0;
      tmr_start_q           <= 1'b0;
      irq_q                 <= 1'b0;
      busy_q                <= 1'b0;
    end else begin
      state_q               <= state_d;
      nv_addr_reg_q         <= nv_addr_reg_d;
      nv_data_reg_q         <= nv_data_reg_d;
      op_addr_q             <= op_addr_d;
      op_data_q             <= op_data_d;
      pointer1_low_q        <= pointer1_low_d;
      pointer1_high_q       <= pointer1_high_d;
      read_arm_q            <= read_arm_d;
      write_arm_q           <= write_arm_d;
      rd_strobe_q           <= rd_strobe_d;
      wr_strobe_q           <= wr_strobe_d;
      global_irq_enable_q   <= global_irq_enable_d;
      nv_write_irq_enable_q <= nv_write_irq_enable_d;
      nv_write_irq_flag_q   <= nv_write_irq_flag_d;
      mem_we_q              <= mem_we_d;
      mem_re_q              <= mem_re_d;
      tmr_start_q           <= tmr_start_d;
      irq_q                 <= irq_d;
      busy_q                <= busy_d;
    end
  end

  // ----------------------------------------------------------------
  // Storage and write timer
  // ----------------------------------------------------------------

  // Array sized by the 8-bit address
  nv_array #(
    .AW (nv_pkg::NV_AW),
    .DW (nv_pkg::NV_DW)
  ) u_array (
    .aclk    (aclk),
    .aresetn (aresetn),
    .we      (mem_we_q),
    .waddr   (op_addr_q),
    .wdata   (op_data_q),
    .re      (mem_re_q),
    .raddr   (op_addr_q),
    .rdata_q (mem_rdata)
  );  // [R21]

  nv_write_timer #(
    .CYCLES (WRITE_CYCLES)
  ) u_timer (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (tmr_start_q),
    .done_q  (tmr_done)
  );

  // Outputs straight from flops
  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rresp   = rresp_q;
  assign s_axi_rdata   = rdata_q;
  assign irq_request   = irq_q;
  assign nv_busy       = busy_q;   // Sleep must wait while high

endmodule

`default_nettype wire

// [bench/nv_byte_ctrl_sva.sv]
// Assertions on the byte store controller's bus handshakes and status pins.
// Bound to nv_byte_ctrl; watches its ports only, one aclk domain.
`timescale 1ns/10ps
`default_nettype none
module nv_ctrl_sva #(
  parameter int unsigned WRITE_CYCLES = nv_pkg::WRITE_CYCLES
) (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        stack_full,
  input wire logic        irq_serviced,
  input wire logic        irq_request,
  input wire logic        nv_busy
);
  // --------------------
  // Properties
  // --------------------
  // Bound of 80 covers the default write length plus jitter
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_take; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  sequence s_rd_take; s_axi_arvalid && s_axi_arready; endsequence
  property p_rst; $rose(aresetn) |-> !nv_busy && !irq_request; endproperty
  a_rst: assert property (p_rst) else $error("busy or irq at release");
  property p_wr_lat; s_wr_take |=> ##1 s_axi_bvalid; endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("late write response");
  property p_rd_lat; s_rd_take |=> s_axi_rvalid; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("late read data");
  property p_b_ref; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_b_ref: assert property (p_b_ref) else $error("write taken while response pending");
  property p_rd_hi; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("upper read bits set");
  property p_stack; stack_full |=> !irq_request; endproperty
  a_stack: assert property (p_stack) else $error("irq with full stack");
  property p_svc; irq_serviced && !nv_busy |=> ##1 !irq_request; endproperty
  a_svc: assert property (p_svc) else $error("irq after service");
  property p_busy; $rose(nv_busy) |-> ##[1:80] !nv_busy; endproperty
  a_busy: assert property (p_busy) else $error("cycle never ends");
endmodule
bind nv_byte_ctrl nv_ctrl_sva #(.WRITE_CYCLES(WRITE_CYCLES)) u_nv_ctrl_sva (.aclk, .aresetn,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .stack_full,
  .irq_serviced, .irq_request, .nv_busy);
`default_nettype wire

// [bench/tb_top.sv]
// Self-checking bench for nv_byte_ctrl, driven over AXI4-Lite.
// Bench drives every input itself; short write timer for speed.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  // --------------------
  // Signals and design
  // --------------------
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, stack_full, irq_serviced, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_request, nv_busy;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, a, d;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [33:0] q[$];
  int          error_cnt, tests_run, seed, i;
  nv_byte_ctrl #(.WRITE_CYCLES(4)) u_nv_byte_ctrl (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .stack_full, .irq_serviced, .irq_request, .nv_busy);
  initial begin
    aclk = 1'h0;
    forever #25 aclk = ~aclk;
  end
  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n >= 200) begin
      error_cnt++;
      finish_test();
    end
  endtask
  // One bus transfer; expected answer noted for the monitor
  task automatic bus(input logic w, input logic [7:0] ad, input logic [7:0] v,
                     input logic [1:0] r);
    int n;
    @(posedge aclk);
    q.push_back({r, 24'h0, w ? 8'h0 : v});
    s_axi_awaddr <= ad;
    s_axi_araddr <= ad;
    s_axi_wdata <= {24'($random(seed)), v};
    s_axi_wstrb <= 4'($random(seed)) | 4'h1;
    s_axi_awvalid <= w;
    s_axi_wvalid <= w;
    s_axi_bready <= w;
    s_axi_arvalid <= !w;
    s_axi_rready <= !w;
    for (n = 0; n < 200; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
      if (s_axi_bvalid || s_axi_rvalid) break;
    end
    s_axi_bready <= 1'h0;
    s_axi_rready <= 1'h0;
    tmo(n);
  endtask
  // Cycle length varies, so poll busy under a bound
  task automatic idle();
    int n;
    for (n = 0; n < 200 && nv_busy !== 1'h0; n++) @(posedge aclk);
    tmo(n);
  endtask
  // Monitor takes the oldest note per response
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) chk({s_axi_bresp, 32'h0}, q.pop_front());
    if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, q.pop_front());
  end
  initial begin
    seed = 71624;
    error_cnt = 0;
    tests_run = 0;
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready,
     stack_full, irq_serviced, s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 60'h0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    bus(0, 8'h10, 8'h00, 2'h0);
    bus(0, 8'h0c, 8'h00, 2'h0);
    bus(0, 8'h1c, 8'h00, 2'h2);
    bus(1, 8'h1c, 8'h00, 2'h2);
    bus(1, 8'h08, 8'h40, 2'h0);
    bus(1, 8'h0c, 8'h01, 2'h0);
    bus(0, 8'h10, 8'h00, 2'h0);
    bus(1, 8'h10, 8'h05, 2'h0);
    bus(0, 8'h18, 8'h00, 2'h0);
    bus(0, 8'h04, 8'h00, 2'h0);
    for (i = 0; i < 3; i++) begin
      a = i ? 8'($random(seed)) : 8'hff;
      d = 8'($random(seed));
      bus(1, 8'h00, a, 2'h0);
      bus(1, 8'h04, d, 2'h0);
      bus(1, 8'h10, 8'h08, 2'h0);
      bus(1, 8'h10, 8'h0c, 2'h0);
      bus(1, 8'h04, ~d, 2'h0);
      bus(1, 8'h14, 8'h07, 2'h0);
      idle();
      bus(0, 8'h10, 8'h08, 2'h0);
      bus(0, 8'h14, 8'h07, 2'h0);
      chk(34'(irq_request), 34'h1);
      stack_full <= 1'h1;
      repeat (2) @(posedge aclk);
      chk(34'(irq_request), 34'h0);
      stack_full <= 1'h0;
      irq_serviced <= 1'h1;
      @(posedge aclk);
      irq_serviced <= 1'h0;
      bus(0, 8'h14, 8'h03, 2'h0);
      bus(1, 8'h14, 8'h02, 2'h0);
      bus(1, 8'h00, a, 2'h0);
      bus(1, 8'h10, 8'h02, 2'h0);
      bus(1, 8'h10, 8'h03, 2'h0);
      idle();
      bus(0, 8'h10, 8'h02, 2'h0);
      bus(0, 8'h04, d, 2'h0);
      bus(0, 8'h04, d, 2'h0);
    end
    finish_test();
  end
endmodule
`default_nettype wire
